// ### rtl/phy_pin_defines.svh
`ifndef PHY_PIN_DEFINES_SVH
`define PHY_PIN_DEFINES_SVH
`define CLK_FREQ_HZ 100000000
`define RESET_TIME_US 1000
`define RESET_CYCLES ((`CLK_FREQ_HZ / 1000000) * `RESET_TIME_US + 1)
`define ACT_BLINK_HZ 10
`define COL_BLINK_HZ 20
`define ACT_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `ACT_BLINK_HZ))
`define COL_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `COL_BLINK_HZ))
`define STRAP_SPEED10_BIT 7
`define STRAP_ACT_BIT 6
`define STRAP_LINK_BIT 5
`define STRAP_DUPCOL_BIT 4
`define STRAP_SPEED100_BIT 3
`define STRAP_RESET_VAL 8'h00
`define MLT3_BYPASS_BIT 1
`define LOOPBACK_BIT 14
`define POWERDOWN_BIT 11
`define AUTONEG_BIT 12
`endif

// ### rtl/phy_pin_pkg.sv
package phy_pin_pkg;
	typedef struct packed {
		logic speed10;
		logic act;
		logic link;
		logic dupcol;
		logic speed100;
	} led_bus_t;
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b11
	} rst_state_t;
endpackage

// ### rtl/blink_gen.sv
`timescale 1ns/1ps
`default_nettype none
module blink_gen #(
	parameter int HALF_CYCLES = 5000000
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	output logic blink_o
);
	logic [31:0] cnt_reg;
	logic blink_reg;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || cnt_reg == 32'(HALF_CYCLES - 1)) begin
			cnt_reg <= 32'h00000000;
		end else begin
			cnt_reg <= cnt_reg + 32'h00000001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			blink_reg <= 1'b0;
		end else if (cnt_reg == 32'(HALF_CYCLES - 1)) begin
			blink_reg <= ~blink_reg;
		end
	end
	assign blink_o = blink_reg;
endmodule
`default_nettype wire

// ### rtl/phy_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_pin_defines.svh"
module phy_pin_ctrl
	import phy_pin_pkg::*;
#(
	parameter int RESET_CYCLES = `RESET_CYCLES,
	parameter int ACT_HALF = `ACT_HALF_CYCLES,
	parameter int COL_HALF = `COL_HALF_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pin_reset_b_i,
	input wire logic pin_pwrdwn_i,
	input wire logic config_in_a_i,
	input wire logic config_in_b_i,
	input wire logic autoneg_strap_i,
	input wire logic powerdown_bit_i,
	input wire logic speed_is_100_i,
	input wire logic link_good_i,
	input wire logic full_duplex_i,
	input wire logic activity_i,
	input wire logic collision_i,
	input wire led_bus_t led_pin_i,
	output led_bus_t led_pin_o,
	output led_bus_t led_pin_oe_o,
	output logic tx_pair_oe_o,
	output logic mii_isolate_o,
	output logic power_down_o,
	output logic reset_done_o,
	output logic [7:0] strap_latch_reg_o,
	output logic mlt3_bypass_o,
	output logic loopback_o,
	output logic [1:0] advert_sel_o,
	output logic advert_valid_o
);
	led_bus_t led_s1_reg, led_s2_reg, led_s3_reg;
	logic [2:0] rst_s_reg, pd_s_reg, cfa_s_reg, cfb_s_reg;
	logic pin_rst_b, pin_pd, cfg_a, cfg_b;
	rst_state_t state_reg;
	logic [31:0] rst_cnt_reg;
	logic [7:0] strap_reg;
	logic bypass_reg, loop_reg, ready_reg, pd_reg;
	logic act_blink, col_blink;
	led_bus_t led_reg;
	logic [1:0] advert_reg;
	logic advert_on_reg;

	// Three-stage sync; only agreeing stages 2 and 3 move the level
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rst_s_reg <= 3'h7;
			pd_s_reg <= 3'h0;
			cfa_s_reg <= 3'h0;
			cfb_s_reg <= 3'h0;
			led_s1_reg <= '0;
			led_s2_reg <= '0;
			led_s3_reg <= '0;
		end else begin
			rst_s_reg <= {rst_s_reg[1:0], pin_reset_b_i};
			pd_s_reg <= {pd_s_reg[1:0], pin_pwrdwn_i};
			cfa_s_reg <= {cfa_s_reg[1:0], config_in_a_i};
			cfb_s_reg <= {cfb_s_reg[1:0], config_in_b_i};
			led_s1_reg <= led_pin_i;
			led_s2_reg <= led_s1_reg;
			led_s3_reg <= led_s2_reg;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_rst_b <= 1'b1;
			pin_pd <= 1'b0;
			cfg_a <= 1'b0;
			cfg_b <= 1'b0;
		end else begin
			if (rst_s_reg[1] == rst_s_reg[2]) pin_rst_b <= rst_s_reg[2];
			if (pd_s_reg[1] == pd_s_reg[2]) pin_pd <= pd_s_reg[2];
			if (cfa_s_reg[1] == cfa_s_reg[2]) cfg_a <= cfa_s_reg[2];
			if (cfb_s_reg[1] == cfb_s_reg[2]) cfg_b <= cfb_s_reg[2];
		end
	end

	// Power-up and pin reset share one timed hold; a pin low of two cycles or more restarts it
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_HOLD;
		end else if (!pin_rst_b) begin
			state_reg <= ST_HOLD;
		end else begin
			case (state_reg)
				ST_HOLD: begin
					state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (rst_cnt_reg == 32'(RESET_CYCLES - 1)) state_reg <= ST_RUN;
				end
				ST_RUN: begin
					state_reg <= ST_RUN;
				end
				default: begin
					state_reg <= ST_HOLD;
				end
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || state_reg != ST_WAIT || !pin_rst_b) begin
			rst_cnt_reg <= 32'h00000000;
		end else begin
			rst_cnt_reg <= rst_cnt_reg + 32'h00000001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= (state_reg == ST_RUN) && pin_rst_b;
		end
	end

	// Strap bits follow the pins all through the timed hold; frozen on the way out
	// Pins still settling keep the last strap, so a slow pull never latches half-way
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			strap_reg <= `STRAP_RESET_VAL;
		end else if (state_reg != ST_RUN && led_s2_reg == led_s3_reg) begin
			strap_reg[`STRAP_SPEED10_BIT] <= led_s3_reg.speed10;
			strap_reg[`STRAP_ACT_BIT] <= led_s3_reg.act;
			strap_reg[`STRAP_LINK_BIT] <= led_s3_reg.link;
			strap_reg[`STRAP_DUPCOL_BIT] <= led_s3_reg.dupcol;
			strap_reg[`STRAP_SPEED100_BIT] <= led_s3_reg.speed100;
		end
	end

	// Config bits track the inputs only with autoneg off
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			bypass_reg <= 1'b0;
			loop_reg <= 1'b0;
		end else if (!autoneg_strap_i) begin
			bypass_reg <= cfg_a;
			loop_reg <= cfg_b;
		end else begin
			bypass_reg <= 1'b0;
			loop_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pd_reg <= 1'b0;
		end else begin
			pd_reg <= pin_pd | powerdown_bit_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			advert_reg <= 2'h0;
			advert_on_reg <= 1'b0;
		end else begin
			advert_reg <= autoneg_strap_i ? {cfg_b, cfg_a} : 2'h0;
			advert_on_reg <= autoneg_strap_i;
		end
	end

	blink_gen #(.HALF_CYCLES(ACT_HALF)) u_act_blink (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.blink_o(act_blink)
	);
	blink_gen #(.HALF_CYCLES(COL_HALF)) u_col_blink (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.blink_o(col_blink)
	);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			led_reg <= '0;
		end else begin
			led_reg.speed10 <= !speed_is_100_i;
			led_reg.speed100 <= speed_is_100_i;
			led_reg.act <= activity_i & act_blink;
			led_reg.link <= link_good_i & (activity_i ? act_blink : 1'b1);
			led_reg.dupcol <= full_duplex_i | (collision_i & col_blink);
		end
	end

	assign led_pin_o = led_reg;
	assign led_pin_oe_o = (ready_reg && !pd_reg) ? 5'h1F : 5'h00;
	assign tx_pair_oe_o = ready_reg && !pd_reg;
	assign mii_isolate_o = pd_reg;
	assign power_down_o = pd_reg;
	assign reset_done_o = ready_reg;
	assign strap_latch_reg_o = strap_reg;
	assign mlt3_bypass_o = bypass_reg;
	assign loopback_o = loop_reg;
	assign advert_sel_o = advert_reg;
	assign advert_valid_o = advert_on_reg;

	property p_pd_or;
		@(posedge clk_i) disable iff (!rst_b_i)
		(pin_pd | powerdown_bit_i) |=> power_down_o;
	endproperty
	a_pd_or: assert property (p_pd_or) else $error("power down missed");
	property p_float;
		@(posedge clk_i) disable iff (!rst_b_i)
		power_down_o |-> (led_pin_oe_o == 5'h00 && !tx_pair_oe_o && mii_isolate_o);
	endproperty
	a_float: assert property (p_float) else $error("pins driven in power down");
	property p_led_in_reset;
		@(posedge clk_i) disable iff (!rst_b_i)
		!reset_done_o |-> led_pin_oe_o == 5'h00;
	endproperty
	a_led_in_reset: assert property (p_led_in_reset) else $error("LED driven in reset");
	property p_ready_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_reg != ST_RUN) |=> !reset_done_o;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready early");
	property p_hold_len;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(reset_done_o) |-> $past(rst_cnt_reg, 2) == 32'(RESET_CYCLES - 1);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("reset too short");
	property p_strap_frozen;
		@(posedge clk_i) disable iff (!rst_b_i)
		reset_done_o && $past(reset_done_o) |-> $stable(strap_latch_reg_o);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen) else $error("strap moved");
	property p_speed;
		@(posedge clk_i) disable iff (!rst_b_i)
		speed_is_100_i |=> led_pin_o.speed100 && !led_pin_o.speed10;
	endproperty
	a_speed: assert property (p_speed) else $error("speed LED wrong");
	property p_full_dup;
		@(posedge clk_i) disable iff (!rst_b_i)
		full_duplex_i |=> led_pin_o.dupcol;
	endproperty
	a_full_dup: assert property (p_full_dup) else $error("duplex LED off");
	property p_loop;
		@(posedge clk_i) disable iff (!rst_b_i)
		!autoneg_strap_i |=> loopback_o == $past(cfg_b) && mlt3_bypass_o == $past(cfg_a);
	endproperty
	a_loop: assert property (p_loop) else $error("config bits wrong");
	property p_idle_act;
		@(posedge clk_i) disable iff (!rst_b_i)
		!activity_i |=> !led_pin_o.act;
	endproperty
	a_idle_act: assert property (p_idle_act) else $error("activity LED lit idle");
	sequence s_hold_end;
		state_reg == ST_WAIT && rst_cnt_reg == 32'(RESET_CYCLES - 1) && pin_rst_b;
	endsequence
	sequence s_run_entered;
		state_reg == ST_RUN && pin_rst_b;
	endsequence
	property p_come_up;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_hold_end ##1 s_run_entered |=> reset_done_o;
	endproperty
	a_come_up: assert property (p_come_up) else $error("ready late");
endmodule
`default_nettype wire

// ### tb/strap_board.sv
`timescale 1ns/1ps
`default_nettype none
module strap_board
	import phy_pin_pkg::*;
#(
	parameter int HOLD = 10
) (
	input wire logic clk_i,
	input wire logic kick_i,
	input wire logic [4:0] strap_i,
	input wire led_bus_t led_drive_i,
	input wire led_bus_t led_oe_i,
	output var led_bus_t led_level_o,
	output logic pin_reset_b_o
);
	int cnt = 0;
	// Pull resistors win only while the pin is released
	assign led_level_o = (led_drive_i & led_oe_i) | (strap_i & ~led_oe_i);
	// Hold shortened for sim; the design's filter ignores lows shorter than two cycles
	always @(posedge clk_i) begin
		if (kick_i) begin
			cnt <= HOLD;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign pin_reset_b_o = (cnt == 0);
endmodule
`default_nettype wire

// ### tb/phy_pin_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module phy_pin_ctrl_bench;
	import phy_pin_pkg::*;
	logic clk_i, rst_b_i, pwr, ca, cb, an, pdb, s100, lg, fd, act, col, kick;
	logic tx_oe, iso, pd, rdy, byp, lpb, aval, prst_b;
	logic [4:0] strap;
	logic [7:0] sreg;
	logic [1:0] asel;
	led_bus_t lin, lo, loe;
	int bad_count = 0;
	int n_checks = 0;
	int n, t;
	phy_pin_ctrl #(.RESET_CYCLES(20), .ACT_HALF(4), .COL_HALF(2)) u_phy_pin_ctrl (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_reset_b_i(prst_b), .pin_pwrdwn_i(pwr),
		.config_in_a_i(ca), .config_in_b_i(cb), .autoneg_strap_i(an), .powerdown_bit_i(pdb),
		.speed_is_100_i(s100), .link_good_i(lg), .full_duplex_i(fd), .activity_i(act),
		.collision_i(col), .led_pin_i(lin), .led_pin_o(lo), .led_pin_oe_o(loe),
		.tx_pair_oe_o(tx_oe), .mii_isolate_o(iso), .power_down_o(pd), .reset_done_o(rdy),
		.strap_latch_reg_o(sreg), .mlt3_bypass_o(byp), .loopback_o(lpb),
		.advert_sel_o(asel), .advert_valid_o(aval));
	strap_board u_strap_board (.clk_i(clk_i), .kick_i(kick), .strap_i(strap),
		.led_drive_i(lo), .led_oe_i(loe), .led_level_o(lin), .pin_reset_b_o(prst_b));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_ready(output int w);
		w = 0;
		while (rdy !== 1'b1 && w < 200) begin
			step(1);
			w++;
		end
		if (w >= 200) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// Counts edges of one LED over a fixed window of 32 cycles
	task automatic toggles(input int b, output int c);
		led_bus_t p;
		c = 0;
		p = lo;
		repeat (32) begin
			step(1);
			if (lo[b] !== p[b]) c++;
			p = lo;
		end
	endtask
	initial begin
		rst_b_i = 1'b0; {pwr, ca, cb, an, pdb, s100, lg, fd, act, col, kick} = 11'h000;
		strap = 5'h15;
		step(20);
		chk("rdy_in_reset", rdy, 8'h00);
		chk("oe_in_reset", loe, 8'h00);
		rst_b_i = 1'b1;
		wait_ready(n);
		chk("reset_long", n > 20, 8'h01);
		chk("strap", sreg, {strap, 3'h0});
		chk("oe_run", loe, 8'h1F);
		$display("test reset done");
		step(2);
		chk("spd10", {lo.speed10, lo.speed100}, 8'h02);
		s100 = 1'b1; fd = 1'b1; lg = 1'b1;
		step(2);
		chk("spd100", {lo.speed10, lo.speed100}, 8'h01);
		chk("full_dup", lo.dupcol, 8'h01);
		chk("link_on", lo.link, 8'h01);
		act = 1'b1;
		toggles(3, t);
		chk("act_blink", t >= 7 && t <= 9, 8'h01);
		toggles(2, t);
		chk("link_blink", t >= 7 && t <= 9, 8'h01);
		act = 1'b0; fd = 1'b0; col = 1'b1;
		toggles(1, t);
		chk("col_blink", t >= 15 && t <= 17, 8'h01);
		col = 1'b0;
		$display("test leds done");
		for (int i = 0; i < 8; i++) begin
			an = i[2]; ca = i[0]; cb = i[1];
			step(8);
			chk("bypass", byp, an ? 8'h00 : 8'(i[0]));
			chk("loopback", lpb, an ? 8'h00 : 8'(i[1]));
			chk("advert", {aval, asel}, an ? 8'(i[2:0]) : 8'h00);
		end
		$display("test config done");
		pdb = 1'b1;
		step(2);
		chk("pd_bit", pd, 8'h01);
		chk("pd_float", {loe, tx_oe, iso}, 8'h01);
		pdb = 1'b0; pwr = 1'b1;
		step(8);
		chk("pd_pin", {pd, loe, tx_oe, iso}, 8'h81);
		pwr = 1'b0;
		step(8);
		chk("pd_off", {pd, loe, tx_oe, iso}, 8'h7E);
		$display("test powerdown done");
		strap = 5'h0A; kick = 1'b1;
		step(1);
		kick = 1'b0;
		step(8);
		chk("rdy_pin_rst", rdy, 8'h00);
		chk("oe_pin_rst", loe, 8'h00);
		wait_ready(n);
		chk("strap_again", sreg, {strap, 3'h0});
		$display("test pin reset done");
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
